// *** inc/ssc_params.svh ***
// Purpose: Constants of the synchronous serial clock and transmit block
// Assumes: fc is the 20 MHz system clock
// Notes: Half-period counts are terminal values of the divider
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH

// ****************************************
// Modes and clock select codes
// ****************************************
`define SSC_MODE_TX 2'h0
`define SSC_SEL_EXT 3'h7
`define SSC_SEL_DIV12 3'h0
`define SSC_SEL_DIV8 3'h1
`define SSC_SEL_DIV7 3'h2
`define SSC_SEL_DIV6 3'h3
`define SSC_SEL_DIV5 3'h4
`define SSC_SEL_DIV4 3'h5
`define SSC_SEL_DIV3 3'h6

// ****************************************
// Half-period terminal counts
// ****************************************
`define SSC_HALF_DIV12 12'h7ff
`define SSC_HALF_DIV8 12'h07f
`define SSC_HALF_DIV7 12'h03f
`define SSC_HALF_DIV6 12'h01f
`define SSC_HALF_DIV5 12'h00f
`define SSC_HALF_DIV4 12'h007
`define SSC_HALF_DIV3 12'h003
`define SSC_HALF_FS4 12'h007

// ****************************************
// Byte framing and reset values
// ****************************************
`define SSC_CNT_ZERO 4'h0
`define SSC_CNT_ONE 4'h1
`define SSC_CNT_LAST 4'h7
`define SSC_CNT_FULL 4'h8
`define SSC_BYTE_RESET 8'h00
`define SSC_DIV_RESET 12'h000

`endif

// *** inc/ssc_pkg.sv ***
// Purpose: Types of the synchronous serial clock and transmit block
// Assumes: Used with ssc_params.svh
// Notes: One-hot transfer states
`default_nettype none

package ssc_pkg;

  typedef enum logic [4:0] {
    SSC_IDLE  = 5'h01,
    SSC_LOAD  = 5'h02,
    SSC_SHIFT = 5'h04,
    SSC_WAIT  = 5'h08,
    SSC_ERROR = 5'h10
  } ssc_state_t;

  typedef struct packed {
    ssc_state_t state;
    logic run;
    logic tx_empty;
    logic underrun;
    logic active;
    logic count_flag;
    logic irq;
    logic irq_pend;
    logic tx_empty_pend;
    logic [7:0] buf_q;
    logic [7:0] shreg;
    logic [3:0] cnt;
    logic sck;
    logic sck_oe;
    logic so;
    logic sck_prev;
  } ssc_top_t;

  typedef struct packed {
    logic [11:0] cnt;
    logic tick;
  } ssc_div_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } ssc_sync_t;

endpackage

`default_nettype wire

// *** verilog/ssc_pin_sync.sv ***
// Purpose: Two-stage synchroniser for the serial clock and data pins
// Assumes: Pins are asynchronous to clk_in
// Notes: First stage feeds only the second
`default_nettype none

module ssc_pin_sync
  import ssc_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic [1:0] pins_in,
  output logic [1:0] pins_out
);

  ssc_sync_t st;
  ssc_sync_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = pins_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= '1;
    end else if (clk_en_in) begin
      st <= next_st;
    end
  end

  assign pins_out = st.s2;

endmodule

`default_nettype wire

// *** verilog/ssc_clk_div.sv ***
// Purpose: Serial clock divider giving one tick per half period
// Assumes: fs_tick_in is a one-cycle pulse at the low-frequency rate
// Notes: Cleared outside the load and shift states
`include "ssc_params.svh"
`default_nettype none

module ssc_clk_div
  import ssc_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic clear_in,
  input wire logic [2:0] sel_in,
  input wire logic slow_in,
  input wire logic fs_tick_in,
  output logic tick_out
);

  ssc_div_t st;
  ssc_div_t next_st;
  logic [11:0] limit;
  logic use_fs;

  always_comb begin
    use_fs = slow_in && (sel_in == `SSC_SEL_DIV12);
    case (sel_in)
      `SSC_SEL_DIV12: limit = use_fs ? `SSC_HALF_FS4 : `SSC_HALF_DIV12;
      `SSC_SEL_DIV8: limit = `SSC_HALF_DIV8;
      `SSC_SEL_DIV7: limit = `SSC_HALF_DIV7;
      `SSC_SEL_DIV6: limit = `SSC_HALF_DIV6;
      `SSC_SEL_DIV5: limit = `SSC_HALF_DIV5;
      `SSC_SEL_DIV4: limit = `SSC_HALF_DIV4;
      default: limit = `SSC_HALF_DIV3;
    endcase
    next_st = st;
    next_st.tick = 1'b0;
    if (clear_in) begin
      next_st.cnt = `SSC_DIV_RESET;
    end else if (!use_fs || fs_tick_in) begin
      if (st.cnt >= limit) begin
        next_st.cnt = `SSC_DIV_RESET;
        next_st.tick = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= '0;
    end else if (clk_en_in) begin
      st <= next_st;
    end
  end

  assign tick_out = st.tick;

endmodule

`default_nettype wire

// *** verilog/ssc_top.sv ***
// Purpose: Serial clock, bit order and transmit mode of an 8-bit synchronous serial port
// Assumes: Control bits arrive as plain ports from logic on clk_in
// Notes: Receive path only shifts into the shared register
`include "ssc_params.svh"
`default_nettype none

module ssc_top
  import ssc_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic ctrl_wr_in,
  input wire logic transfer_run_in,
  input wire logic force_stop_in,
  input wire logic [1:0] transfer_mode_select_in,
  input wire logic [2:0] clock_select_in,
  input wire logic bit_order_select_in,
  input wire logic slow_divider_option_in,
  input wire logic low_speed_mode_in,
  input wire logic fs_tick_in,
  input wire logic tx_buffer_wr_in,
  input wire logic [7:0] tx_buffer_in,
  input wire logic tx_underrun_clear_in,
  input wire logic serial_clock_pin_in,
  input wire logic serial_in_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_out,
  output logic serial_out_pin_out,
  output logic transfer_run_out,
  output logic transfer_active_flag_out,
  output logic shift_count_flag_out,
  output logic tx_buffer_empty_out,
  output logic tx_underrun_error_out,
  output logic serial_irq_out
);

  // ****************************************
  // Pin synchroniser and divider
  // ****************************************
  ssc_top_t st;
  ssc_top_t next_st;
  logic [1:0] pins_sync;
  logic div_tick;
  logic div_clear;
  logic ext;
  logic pin_fall;
  logic pin_rise;
  logic ev_fall;
  logic ev_rise;
  logic out_bit;

  ssc_pin_sync u_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .pins_in({serial_in_pin_in, serial_clock_pin_in}),
    .pins_out(pins_sync)
  );

  assign div_clear = !(st.state == SSC_LOAD || st.state == SSC_SHIFT);

  ssc_clk_div u_div (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .clear_in(div_clear),
    .sel_in(clock_select_in),
    .slow_in(slow_divider_option_in || low_speed_mode_in),
    .fs_tick_in(fs_tick_in),
    .tick_out(div_tick)
  );

  // ****************************************
  // Shift edges
  // ****************************************
  always_comb begin
    ext = (clock_select_in == `SSC_SEL_EXT);
    pin_fall = st.sck_prev && !pins_sync[0];
    pin_rise = !st.sck_prev && pins_sync[0];
    if (ext) begin
      ev_fall = pin_fall;
      ev_rise = pin_rise;
    end else begin
      ev_fall = div_tick && st.sck && (st.state == SSC_SHIFT);
      ev_rise = div_tick && !st.sck && (st.state == SSC_SHIFT);
    end
    out_bit = bit_order_select_in ? st.buf_q[0] : st.buf_q[7];
  end

  // ****************************************
  // Transfer control
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.irq = 1'b0;
    next_st.sck_prev = pins_sync[0];
    next_st.sck_oe = !ext;
    if (ctrl_wr_in) begin
      next_st.run = transfer_run_in;
    end
    if (tx_buffer_wr_in && st.tx_empty) begin
      next_st.buf_q = tx_buffer_in;
      next_st.tx_empty = 1'b0;
    end
    if (tx_underrun_clear_in) begin
      next_st.underrun = 1'b0;
    end
    if (!ext && st.state == SSC_SHIFT && div_tick) begin
      next_st.sck = ~st.sck;
    end
    if (ev_fall && st.irq_pend) begin
      next_st.irq = 1'b1;
      next_st.irq_pend = 1'b0;
    end
    case (st.state)
      SSC_IDLE: begin
        next_st.sck = 1'b1;
        next_st.cnt = `SSC_CNT_ZERO;
        if (st.run && transfer_mode_select_in == `SSC_MODE_TX) begin
          if (ext) begin
            next_st.state = SSC_SHIFT;
          end else if (!st.tx_empty) begin
            next_st.state = SSC_LOAD;
          end
        end
      end
      SSC_LOAD: begin
        next_st.sck = 1'b1;
        if (div_tick) begin
          next_st.state = SSC_SHIFT;
        end
      end
      SSC_WAIT: begin
        next_st.sck = 1'b1;
        if (!st.run) begin
          next_st.state = SSC_IDLE;
          next_st.active = 1'b0;
        end else if (!st.tx_empty) begin
          next_st.state = SSC_LOAD;
        end
      end
      SSC_SHIFT: begin
        if (st.cnt == `SSC_CNT_ZERO && !st.run) begin
          // Run cleared between bytes: stop, clock pin high
          next_st.state = SSC_IDLE;
          next_st.active = 1'b0;
          next_st.sck = 1'b1;
        end else if (ev_fall) begin
          if (st.cnt == `SSC_CNT_ZERO) begin
            next_st.active = 1'b1;
            if (!st.tx_empty) begin
              next_st.shreg = st.buf_q;
              next_st.tx_empty_pend = 1'b1;
              next_st.so = out_bit;
              next_st.cnt = `SSC_CNT_ONE;
              next_st.count_flag = 1'b1;
            end else begin
              next_st.underrun = 1'b1;
              next_st.irq_pend = 1'b1;
              next_st.so = 1'b1;
              next_st.state = SSC_ERROR;
            end
          end else begin
            next_st.so = bit_order_select_in ? st.shreg[0] : st.shreg[7];
            next_st.cnt = st.cnt + `SSC_CNT_ONE;
            if (st.cnt == `SSC_CNT_LAST) begin
              next_st.count_flag = 1'b0;
            end
          end
        end
        if (ev_rise && st.cnt != `SSC_CNT_ZERO) begin
          if (bit_order_select_in) begin
            next_st.shreg = {pins_sync[1], st.shreg[7:1]};
          end else begin
            next_st.shreg = {st.shreg[6:0], pins_sync[1]};
          end
          if (st.tx_empty_pend) begin
            next_st.tx_empty = 1'b1;
            next_st.tx_empty_pend = 1'b0;
            next_st.irq_pend = 1'b1;
          end
          if (st.cnt == `SSC_CNT_FULL) begin
            next_st.cnt = `SSC_CNT_ZERO;
            if (!st.run) begin
              next_st.state = SSC_IDLE;
              next_st.active = 1'b0;
            end else if (!ext && next_st.tx_empty) begin
              next_st.state = SSC_WAIT;
            end
          end
        end
      end
      SSC_ERROR: begin
        next_st.so = 1'b1;
        next_st.sck = 1'b1;
      end
      default: begin
        next_st.state = SSC_IDLE;
      end
    endcase
    if (force_stop_in) begin
      next_st.state = SSC_IDLE;
      next_st.run = 1'b0;
      next_st.tx_empty = 1'b1;
      next_st.underrun = 1'b0;
      next_st.active = 1'b0;
      next_st.count_flag = 1'b0;
      next_st.irq_pend = 1'b0;
      next_st.tx_empty_pend = 1'b0;
      next_st.buf_q = `SSC_BYTE_RESET;
      next_st.shreg = `SSC_BYTE_RESET;
      next_st.cnt = `SSC_CNT_ZERO;
      next_st.sck = 1'b1;
      next_st.so = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= '0;
      st.state <= SSC_IDLE;
      st.tx_empty <= 1'b1;
      st.sck <= 1'b1;
      st.so <= 1'b1;
      st.sck_prev <= 1'b1;
    end else if (clk_en_in) begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign serial_clock_pin_out = st.sck;
  assign serial_clock_pin_oe_out = st.sck_oe;
  assign serial_out_pin_out = st.so;
  assign transfer_run_out = st.run;
  assign transfer_active_flag_out = st.active;
  assign shift_count_flag_out = st.count_flag;
  assign tx_buffer_empty_out = st.tx_empty;
  assign tx_underrun_error_out = st.underrun;
  assign serial_irq_out = st.irq;

  // ****************************************
  // Assertions
  // ****************************************
  property p_idle_high;
    @(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (st.state == SSC_IDLE || st.state == SSC_LOAD) |-> st.sck;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("clock pin not high while idle");

  property p_int_drive;
    @(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (clock_select_in != `SSC_SEL_EXT) |=> st.sck_oe;
  endproperty
  a_int_drive: assert property (p_int_drive) else $error("internal clock not driven");

  property p_ext_input;
    @(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (clock_select_in == `SSC_SEL_EXT) |=> !st.sck_oe;
  endproperty
  a_ext_input: assert property (p_ext_input) else $error("external clock pin driven");

  property p_wait_stopped;
    @(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (st.state == SSC_WAIT) |-> (st.sck && (st.tx_empty || $past(tx_buffer_wr_in)));
  endproperty
  a_wait_stopped: assert property (p_wait_stopped) else $error("clock runs during wait");

  property p_write_clears;
    @(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (tx_buffer_wr_in && st.tx_empty && !force_stop_in) |=> !st.tx_empty;
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("buffer write kept empty flag");

  property p_active_rise;
    @(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (st.state == SSC_SHIFT && st.cnt == `SSC_CNT_ZERO && st.run && ev_fall && !force_stop_in) |=> st.active;
  endproperty
  a_active_rise: assert property (p_active_rise) else $error("active flag missed first fall");

  property p_count_window;
    @(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (st.state == SSC_SHIFT) |-> (st.count_flag == (st.cnt != `SSC_CNT_ZERO && st.cnt != `SSC_CNT_FULL));
  endproperty
  a_count_window: assert property (p_count_window) else $error("shift count flag out of window");

  property p_first_bit;
    @(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (st.state == SSC_SHIFT && st.cnt == `SSC_CNT_ZERO && st.run && ev_fall && !st.tx_empty && !force_stop_in)
      |=> (st.so == (bit_order_select_in ? $past(st.buf_q[0]) : $past(st.buf_q[7])));
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("wrong first bit");

  property p_underrun;
    @(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (ext && st.state == SSC_SHIFT && st.cnt == `SSC_CNT_ZERO && st.run && ev_fall && st.tx_empty && !force_stop_in)
      |=> (st.underrun && st.state == SSC_ERROR);
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not flagged");

  property p_err_hold;
    @(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (st.underrun && !tx_underrun_clear_in && !force_stop_in) |=> st.underrun;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag lost");

  property p_force;
    @(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    force_stop_in |=> (st.state == SSC_IDLE && !st.run && st.tx_empty && !st.active && !st.underrun);
  endproperty
  a_force: assert property (p_force) else $error("force stop incomplete");

  c_byte_done: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    st.state == SSC_SHIFT && st.cnt == `SSC_CNT_FULL ##1 st.cnt == `SSC_CNT_ZERO);
  c_wait: cover property (@(posedge clk_in) disable iff (sys_rst_in) st.state == SSC_WAIT);
  c_error: cover property (@(posedge clk_in) disable iff (sys_rst_in) st.state == SSC_ERROR);
  c_irq: cover property (@(posedge clk_in) disable iff (sys_rst_in) st.irq);

endmodule

`default_nettype wire

// *** verif/ssc_partner.sv ***
// Purpose: External serial device facing the transmit port
// Assumes: Clock pin has a pull-up and idles high
// Notes: Collects bytes on rising edges; can source the clock
`default_nettype none

module ssc_partner (
  input wire logic clk_in,
  input wire logic sck_in,
  input wire logic so_in,
  input wire logic order_in,
  output logic sck_out,
  output logic sck_oe_out,
  output logic si_out
);
  timeunit 1ns;
  timeprecision 1ns;
  parameter int PHASE = 6;
  logic [7:0] sh = 8'h00;
  int nb = 0;
  logic [7:0] rx_q[$];

  initial begin
    sck_out = 1'b1;
    sck_oe_out = 1'b0;
    si_out = 1'b0;
  end

  // ****************************************
  // Receive side
  // ****************************************
  always @(posedge sck_in) begin
    si_out <= ~si_out;
    sh = order_in ? {so_in, sh[7:1]} : {sh[6:0], so_in};
    nb++;
    if (nb == 8) begin
      rx_q.push_back(sh);
      nb = 0;
    end
  end

  // ****************************************
  // Clock source, still outside frames
  // ****************************************
  task automatic pulses(input int n);
    sck_oe_out = 1'b1;
    repeat (n) begin
      repeat (PHASE) @(posedge clk_in);
      #1;
      sck_out = 1'b0;
      repeat (PHASE) @(posedge clk_in);
      #1;
      sck_out = 1'b1;
    end
    repeat (PHASE) @(posedge clk_in);
    #1;
    sck_oe_out = 1'b0;
  endtask
endmodule

`default_nettype wire

// *** verif/sync_serial_clock_and_transmit_tb.sv ***
// Purpose: Self-checking bench of the serial clock and transmit block
// Assumes: Partner model receives the bytes
// Notes: Expected bytes are kept in a queue
`default_nettype none

module sync_serial_clock_and_transmit_tb;
  import ssc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Stimulus, design and partner
  // ****************************************
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cw = 1'b0, rv = 1'b0, stop = 1'b0, wr = 1'b0, clr = 1'b0, ord = 1'b0, slow = 1'b0, fs_tick = 1'b0;
  logic lsm = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [2:0] sel = 3'h6;
  logic [7:0] data = 8'h00;
  logic sck_o, sck_oe, so, run_o, act, cnt_flg, empty, uerr, irq, p_sck, p_oe, si, pin;
  logic [31:0] seed = 32'h271329e6;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0, fsc = 0, nfall = 0, nrise = 0, nirq = 0, t_first = 0, t_last = 0;
  bit mon = 1'b1;
  logic pin_q = 1'b1;

  always #25 clk_in = ~clk_in;
  // Pull-up when nobody drives
  assign pin = sck_oe ? sck_o : (p_oe ? p_sck : 1'b1);

  ssc_top ssc_top_i (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(1'b1),
    .ctrl_wr_in(cw),
    .transfer_run_in(rv),
    .force_stop_in(stop),
    .transfer_mode_select_in(mode),
    .clock_select_in(sel),
    .bit_order_select_in(ord),
    .slow_divider_option_in(slow),
    .low_speed_mode_in(lsm),
    .fs_tick_in(fs_tick),
    .tx_buffer_wr_in(wr),
    .tx_buffer_in(data),
    .tx_underrun_clear_in(clr),
    .serial_clock_pin_in(pin),
    .serial_in_pin_in(si),
    .serial_clock_pin_out(sck_o),
    .serial_clock_pin_oe_out(sck_oe),
    .serial_out_pin_out(so),
    .transfer_run_out(run_o),
    .transfer_active_flag_out(act),
    .shift_count_flag_out(cnt_flg),
    .tx_buffer_empty_out(empty),
    .tx_underrun_error_out(uerr),
    .serial_irq_out(irq)
  );

  ssc_partner ssc_partner_i (
    .clk_in(clk_in),
    .sck_in(pin),
    .so_in(so),
    .order_in(ord),
    .sck_out(p_sck),
    .sck_oe_out(p_oe),
    .si_out(si)
  );

  // ****************************************
  // Helpers and monitors
  // ****************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk_in) begin
    #1;
    fsc++;
    fs_tick = (fsc % 4 == 0);
  end

  always @(posedge clk_in) begin
    cyc++;
    if (mon && pin_q && !pin) begin
      if (nfall == 0) t_first = cyc;
      t_last = cyc;
      nfall++;
      if (sck_oe) chk(act, 1'b1);
    end
    if (mon && !pin_q && pin) begin
      chk(cnt_flg, (nrise % 8) != 7);
      nrise++;
    end
    if (irq) nirq++;
    pin_q <= pin;
  end

  always @(posedge clk_in) begin
    if (cyc == 70000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask

  task automatic ctrl(input logic r);
    cw = 1'b1;
    rv = r;
    tick();
    cw = 1'b0;
    tick();
  endtask

  task automatic wr_buf(input logic [31:0] d);
    wr = 1'b1;
    data = d[7:0];
    tick();
    wr = 1'b0;
    exp_q.push_back(d[7:0]);
    chk(empty, 1'b0);
    tick();
  endtask

  task automatic fstop();
    stop = 1'b1;
    tick();
    stop = 1'b0;
    tick();
    chk(run_o, 1'b0);
    chk(empty, 1'b1);
    chk(act, 1'b0);
    chk(uerr, 1'b0);
  endtask

  task automatic clear_all();
    nfall = 0;
    nrise = 0;
    nirq = 0;
    exp_q.delete();
    ssc_partner_i.rx_q.delete();
    ssc_partner_i.nb = 0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic tx_int(input logic [2:0] s, input logic o, input int n, input bit gap, input int per);
    int t;
    int nf;
    sel = s;
    ord = o;
    clear_all();
    ctrl(1'b1);
    repeat (per) tick();
    chk(sck_oe, 1'b1);
    chk(act, 1'b0);
    chk(pin, 1'b1);
    for (int k = 0; k < n; k++) begin
      if (k > 0 && gap) begin
        for (t = 0; t < 20 * per && nfall < 8 * k; t++) tick();
        repeat (2 * per) tick();
        chk(nfall, 8 * k);
        chk(pin, 1'b1);
      end
      if (k > 0 && !gap) for (t = 0; t < 20 * per && empty !== 1'b1; t++) tick();
      nf = nfall;
      t = cyc;
      wr_buf(xs());
      while (cyc - t < per + 4 && nfall == nf) tick();
      chk(nfall > nf, 1'b1);
    end
    for (t = 0; t < 20 * per * n && ssc_partner_i.rx_q.size() < n; t++) tick();
    repeat (per) tick();
    chk(ssc_partner_i.rx_q.size(), n);
    foreach (exp_q[i]) chk(ssc_partner_i.rx_q[i], exp_q[i]);
    chk(nirq, n);
    if (!gap) chk(t_last - t_first, (8 * n - 1) * per);
    chk(act, 1'b1);
    ctrl(1'b0);
    repeat (3) tick();
    chk(act, 1'b0);
    chk(pin, 1'b1);
  endtask

  task automatic tx_ext(input logic o, input bit under);
    sel = 3'h7;
    ord = o;
    clear_all();
    mon = !under;
    tick();
    if (!under) wr_buf(xs());
    ctrl(1'b1);
    ssc_partner_i.pulses(under ? 2 : 8);
    ctrl(1'b0);
    repeat (8) tick();
    chk(sck_oe, 1'b0);
    if (!under) begin
      chk(ssc_partner_i.rx_q[0], exp_q[0]);
      chk(nirq, 1);
      chk(act, 1'b0);
    end else begin
      chk(uerr, 1'b1);
      chk(so, 1'b1);
      chk(nirq, 1);
      clr = 1'b1;
      tick();
      clr = 1'b0;
      tick();
      chk(uerr, 1'b0);
      fstop();
    end
    mon = 1'b1;
  endtask

  initial begin
    logic [31:0] r;
    repeat (16) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    tick();
    chk(pin, 1'b1);
    chk(so, 1'b1);
    chk(empty, 1'b1);
    chk(uerr, 1'b0);
    chk(act, 1'b0);
    chk(cnt_flg, 1'b0);
    mode = 2'h1;
    clear_all();
    ctrl(1'b1);
    wr_buf(xs());
    repeat (64) tick();
    chk(act, 1'b0);
    chk(nfall, 0);
    fstop();
    mode = 2'h0;
    for (int c = 0; c < 7; c++) begin
      r = xs();
      tx_int(3'(c), r[0], c == 0 ? 1 : 2, c % 2 == 1, c == 0 ? 4096 : 1 << (9 - c));
    end
    slow = 1'b1;
    tx_int(3'h0, 1'b1, 2, 1'b0, 64);
    slow = 1'b0;
    lsm = 1'b1;
    tx_int(3'h0, 1'b0, 2, 1'b1, 64);
    lsm = 1'b0;
    tx_ext(1'b0, 1'b0);
    tx_ext(1'b1, 1'b0);
    tx_ext(1'b0, 1'b1);
    print_verdict();
  end
endmodule

`default_nettype wire
